// >>> rtl/asc_defines.svh
// Offsets, field positions, reset values and timing counts of the sequencer
// Assumes inclusion by bare name from the design module and the bench
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// Register byte addresses (index times four)
`define ASC_IDX_STATUS     8'h06
`define ASC_IDX_BOUNDS     8'h01
`define ASC_IDX_CONTROL    8'h08
`define ASC_IDX_PORT       8'h09
`define ASC_ADDR_STATUS    12'h018
`define ASC_ADDR_BOUNDS    12'h004
`define ASC_ADDR_CONTROL   12'h020
`define ASC_ADDR_PORT      12'h024
// Control register fields
`define ASC_CTL_INT_LSB    10
`define ASC_CTL_DIV_LSB    8
`define ASC_CTL_IREF_BIT   7
`define ASC_CTL_CONT_BIT   6
`define ASC_CTL_IE_BIT     5
`define ASC_CTL_PMO_BIT    4
`define ASC_CTL_MASK       16'h0fff
// Status register fields
`define ASC_ST_LAST_LSB    8
`define ASC_ST_REF_READY_BIT   7
`define ASC_ST_START_BIT   6
`define ASC_ST_FLAG_BIT    5
`define ASC_ST_CFGSEL_BIT  4
// Setup entry fields
`define ASC_CFG_REF_BIT    6
`define ASC_CFG_ACQ_BIT    5
`define ASC_CFG_ALGN_BIT   4
`define ASC_CFG_MASK       16'h007f
`define ASC_BOUNDS_MASK    16'h0f77
// Timing counts in converter clocks, flag intervals in samples, register reset value
`define ASC_CONV_CLKS      5'd16
`define ASC_PWRUP_CLKS     5'd20
`define ASC_INT_N12        5'd12
`define ASC_INT_N16        5'd16
`define ASC_RESET_VAL      16'h0000
`endif

// >>> rtl/asc_pkg.sv
// Types for the converter sequencer
// Assumes no other package
package asc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PWRUP,
        ST_ACQ,
        ST_CONV,
        ST_NEXT
    } asc_state_t;
    typedef logic [15:0] asc_word_t;
endpackage

// >>> rtl/asc_seq.sv
// Converter sequencer: APB registers, divider, sequence engine, sample ring
// Assumes a synchronous single-clock system and an analog core that returns a
// 12-bit result by the end of each sixteen-clock conversion
`timescale 1ns/1ps
`include "asc_defines.svh"

// Overview of operation
// - Interval field sets flag per sample, single-mode sequence end, every 12 or 16 samples
// - Converter clock is system clock divided by 1, 2, 4 or 8
// - Each conversion takes exactly sixteen converter clocks
// - Internal reference off: select bit picks supply or external reference
// - Internal reference on and ready: select bit picks supply or internal
// - Single mode runs one sequence, clears start, powers down unless override
// - Continuous mode restarts sequence until software clears start
// - Interrupt request raised while flag set and enable set
// - Without override, power up at start adds 20 clocks; down at end
// - With override, converter stays powered once up
// - Extended acquisition lasts sixteen times count plus one converter clocks
// - Indirect port acts on entry chosen by five-bit selector
// - Sample buffer accessible by software at any time
// - Samples stored from storage start index, incrementing each sample
// - Status shows index of buffer entry last written by the converter
// - Sample aligned left or right per setup entry bit
// - Sample persists until overwritten by software or converter
// - Clearing start stops after conversion, or at once during acquisition
// - Starting a sequence clears the flag; software may clear it too
// - Control fields ignore writes while start is set
// - Port access increments four-bit selector, wrapping, select bit kept
module asc_seq (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic             REF_READY,
    input  wire logic [11:0]      CONV_RESULT,
    output logic                  CONV_POWER,
    output logic                  CONV_CLK_EN,
    output logic                  CONV_SAMPLE,
    output logic [3:0]            CONV_CHANNEL,
    output logic [1:0]            CONV_REF,
    output logic                  IRQ
);
    import asc_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    asc_word_t   ctl_q;
    asc_word_t   bnd_q;
    logic        start_q;
    logic        flag_q;
    logic [4:0]  sel_q;
    logic [3:0]  last_q;
    logic [3:0]  widx_q;
    logic [2:0]  cidx_q;
    asc_state_t  state_q;
    logic [7:0]  cnt_q;
    logic [2:0]  div_q;
    logic [4:0]  nsmp_q;
    logic        pwr_q;
    asc_word_t   buf_q [16];
    logic [6:0]  cfg_q [8];

    // Decoding helpers
    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Access-phase strobes for each register
    wire acc     = PSEL && PENABLE && !PREADY;
    wire wr      = acc && PWRITE;
    wire rd      = acc && !PWRITE;
    wire hit_st  = hit(PADDR, `ASC_ADDR_STATUS);
    wire hit_bd  = hit(PADDR, `ASC_ADDR_BOUNDS);
    wire hit_ct  = hit(PADDR, `ASC_ADDR_CONTROL);
    wire hit_pt  = hit(PADDR, `ASC_ADDR_PORT);
    wire mapped  = hit_st || hit_bd || hit_ct || hit_pt;
    wire wr_st   = wr && hit_st;
    wire wr_lock = wr && !start_q;
    wire port_ac = acc && hit_pt;

    // Field views
    wire [1:0] f_int  = ctl_q[`ASC_CTL_INT_LSB +: 2];
    wire [1:0] f_div  = ctl_q[`ASC_CTL_DIV_LSB +: 2];
    wire       f_iref = ctl_q[`ASC_CTL_IREF_BIT];
    wire       f_cont = ctl_q[`ASC_CTL_CONT_BIT];
    wire       f_ie   = ctl_q[`ASC_CTL_IE_BIT];
    wire       f_pmo  = ctl_q[`ASC_CTL_PMO_BIT];
    wire [3:0] f_acq  = ctl_q[3:0];
    wire [3:0] f_sto  = bnd_q[11:8];
    wire [2:0] f_sst  = bnd_q[6:4];
    wire [2:0] f_send = bnd_q[2:0];
    wire [6:0] cur    = cfg_q[cidx_q];

    // Status word and port read mux
    wire asc_word_t st_word = {4'h0, last_q, REF_READY && f_iref, start_q, flag_q, sel_q};
    wire asc_word_t port_rd = sel_q[4] ? {9'h000, cfg_q[sel_q[2:0]]} : buf_q[sel_q[3:0]];
    wire asc_word_t rd_word = hit_st ? st_word :
                              hit_bd ? bnd_q :
                              hit_ct ? (ctl_q & `ASC_CTL_MASK) : port_rd;

    // ----------------------------------------------------------------
    // Converter clock divider
    // ----------------------------------------------------------------
    // Tick once per converter clock: every 1, 2, 4 or 8 system clocks
    wire [2:0] div_max = 3'((4'h1 << f_div) - 4'h1);
    wire       tick    = (div_q >= div_max);

    // ----------------------------------------------------------------
    // Sequence engine
    // ----------------------------------------------------------------
    wire [7:0] acq_len   = 8'({f_acq, 4'h0} + 8'h10);
    wire       last_cfg  = (cidx_q == f_send);
    wire       start_set = wr_st && PWDATA[`ASC_ST_START_BIT] && !start_q;
    wire       conv_done = (state_q == ST_CONV) && tick && (cnt_q == 8'(`ASC_CONV_CLKS - 5'd1));
    wire       seq_end   = conv_done && last_cfg;
    wire       auto_stop = seq_end && !f_cont;
    wire [4:0] nsmp_inc  = nsmp_q + 5'd1;
    wire [4:0] n_thresh  = f_int[0] ? `ASC_INT_N16 : `ASC_INT_N12;
    // Flag condition per interval code
    wire       flag_evt  = conv_done && ((f_int == 2'b00) ||
                           (f_int == 2'b01 && auto_stop) ||
                           (f_int[1] && nsmp_inc == n_thresh));
    wire asc_word_t sample = cur[`ASC_CFG_ALGN_BIT] ? {CONV_RESULT, 4'h0} :
                             {{4{cur[3] & CONV_RESULT[11]}}, CONV_RESULT};

    // Next state of the engine
    asc_state_t state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (start_q) state_d = pwr_q ? ST_ACQ : ST_PWRUP;
            ST_PWRUP: if (!start_q) state_d = ST_IDLE;
                      else if (tick && cnt_q == 8'(`ASC_PWRUP_CLKS - 5'd1)) state_d = ST_ACQ;
            ST_ACQ:   if (!start_q) state_d = ST_IDLE;
                      else if (!cur[`ASC_CFG_ACQ_BIT] || (tick && cnt_q == acq_len - 8'h01))
                          state_d = ST_CONV;
            ST_CONV:  if (conv_done) state_d = ST_NEXT;
            ST_NEXT:  if (!start_q) state_d = ST_IDLE;
                      else state_d = ST_ACQ;
            default:  state_d = ST_IDLE;
        endcase
    end

    // Engine registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            cnt_q   <= 8'h00;
            div_q   <= 3'h0;
            cidx_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            div_q   <= (tick || state_q == ST_IDLE) ? 3'h0 : div_q + 3'h1;
            cnt_q   <= (state_d != state_q) ? 8'h00 : (tick ? cnt_q + 8'h01 : cnt_q);
            if (state_q == ST_IDLE) cidx_q <= f_sst;
            else if (conv_done) cidx_q <= last_cfg ? f_sst : cidx_q + 3'h1;
        end
    end

    // Power control: up when power-up completes, held by override
    always_ff @(posedge CLK) begin
        if (RST) pwr_q <= 1'b0;
        else if (state_q == ST_PWRUP && state_d == ST_ACQ) pwr_q <= 1'b1;
        else if (state_q != ST_IDLE && state_d == ST_IDLE && !f_pmo) pwr_q <= 1'b0;
        else if (state_q == ST_IDLE && !start_q && !f_pmo) pwr_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Control, bounds, start, flag and selector
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctl_q   <= `ASC_RESET_VAL;
            bnd_q   <= `ASC_RESET_VAL;
            start_q <= 1'b0;
            flag_q  <= 1'b0;
            sel_q   <= 5'h00;
            nsmp_q  <= 5'h00;
        end else begin
            if (wr_lock && hit_ct) ctl_q <= PWDATA[15:0] & `ASC_CTL_MASK;
            if (wr_lock && hit_bd) bnd_q <= PWDATA[15:0] & `ASC_BOUNDS_MASK;
            if (auto_stop) start_q <= 1'b0;
            else if (wr_st) start_q <= PWDATA[`ASC_ST_START_BIT];
            if (flag_evt) flag_q <= 1'b1;
            else if (start_set) flag_q <= 1'b0;
            else if (wr_st && !PWDATA[`ASC_ST_FLAG_BIT]) flag_q <= 1'b0;
            if (start_set) nsmp_q <= 5'h00;
            else if (conv_done) nsmp_q <= (nsmp_inc == n_thresh) ? 5'h00 : nsmp_inc;
            if (wr_st) sel_q <= PWDATA[4:0];
            else if (port_ac) sel_q <= {sel_q[4], sel_q[3:0] + 4'h1};
        end
    end

    // Sample ring and setup entries; converter write wins over software
    always_ff @(posedge CLK) begin
        if (RST) begin
            widx_q <= 4'h0;
            last_q <= 4'h0;
        end else begin
            if (state_q == ST_IDLE) widx_q <= f_sto;
            else if (conv_done) widx_q <= widx_q + 4'h1;
            if (conv_done) last_q <= widx_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_buf
            always_ff @(posedge CLK) begin
                if (RST) buf_q[gi] <= `ASC_RESET_VAL;
                else if (conv_done && widx_q == 4'(gi)) buf_q[gi] <= sample;
                else if (wr && hit_pt && !sel_q[4] && sel_q[3:0] == 4'(gi))
                    buf_q[gi] <= PWDATA[15:0];
            end
        end
        for (gi = 0; gi < 8; gi++) begin : g_cfg
            always_ff @(posedge CLK) begin
                if (RST) cfg_q[gi] <= 7'h00;
                else if (wr_lock && hit_pt && sel_q[4] && sel_q[2:0] == 3'(gi))
                    cfg_q[gi] <= PWDATA[6:0];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            PRDATA       <= 32'h0000_0000;
            PREADY       <= 1'b0;
            PSLVERR      <= 1'b0;
            CONV_POWER   <= 1'b0;
            CONV_CLK_EN  <= 1'b0;
            CONV_SAMPLE  <= 1'b0;
            CONV_CHANNEL <= 4'h0;
            CONV_REF     <= 2'b00;
            IRQ          <= 1'b0;
        end else begin
            PREADY       <= acc;
            PSLVERR      <= acc && !mapped;
            PRDATA       <= (rd && mapped) ? {16'h0000, rd_word} : 32'h0000_0000;
            CONV_POWER   <= pwr_q || (state_q == ST_PWRUP);
            CONV_CLK_EN  <= tick && state_q != ST_IDLE;
            CONV_SAMPLE  <= state_q == ST_ACQ;
            CONV_CHANNEL <= cur[3:0];
            // 00 supply, 01 external, 10 internal
            CONV_REF     <= !cur[`ASC_CFG_REF_BIT] ? 2'b00 :
                            (f_iref ? 2'b10 : 2'b01);
            IRQ          <= flag_q && f_ie;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_done_single;
        conv_done && last_cfg && !f_cont;
    endsequence

    a_single_stop_clear: assert property (@(posedge CLK) disable iff (RST)
        s_done_single |=> !start_q) else $error("start not cleared at sequence end");
    a_irq_follows_flag: assert property (@(posedge CLK) disable iff (RST)
        (flag_q && f_ie) |=> IRQ) else $error("interrupt not raised");
    a_ctl_write_lock: assert property (@(posedge CLK) disable iff (RST)
        (start_q && wr && hit_ct) |=> $stable(ctl_q)) else $error("control changed while running");
    a_sel_autoinc: assert property (@(posedge CLK) disable iff (RST)
        (port_ac && !wr_st) |=> sel_q[3:0] == 4'($past(sel_q[3:0]) + 4'h1) && $stable(sel_q[4]))
        else $error("selector not incremented");
    a_ring_advance: assert property (@(posedge CLK) disable iff (RST)
        conv_done |=> last_q == $past(widx_q) && widx_q == 4'($past(widx_q) + 4'h1))
        else $error("ring index wrong");
    a_conv_length: assert property (@(posedge CLK) disable iff (RST)
        (state_q == ST_ACQ && state_d == ST_CONV && f_div == 2'b00) |=> ##15 conv_done)
        else $error("conversion length wrong");
    a_flag_every: assert property (@(posedge CLK) disable iff (RST)
        (conv_done && f_int == 2'b00) |=> flag_q) else $error("flag not set per sample");
    a_flag_start_clr: assert property (@(posedge CLK) disable iff (RST)
        (start_set && !flag_evt) |=> !flag_q) else $error("flag not cleared on start");
    a_ctl_reserved: assert property (@(posedge CLK) disable iff (RST)
        ctl_q[15:12] == 4'h0) else $error("reserved control bits set");

    // ----------------------------------------------------------------
    // Engine step checks
    // ----------------------------------------------------------------
    // Plain acquisition with start still set
    sequence s_acq_plain;
        state_q == ST_ACQ && !cur[`ASC_CFG_ACQ_BIT] && start_q;
    endsequence

    // Acquisition while software has cleared start
    sequence s_acq_stop;
        state_q == ST_ACQ && !start_q;
    endsequence

    // Conversion not yet at its last converter clock
    sequence s_conv_busy;
        state_q == ST_CONV && !conv_done;
    endsequence

    // End of one conversion with start still set
    sequence s_restart;
        state_q == ST_NEXT && start_q;
    endsequence

    // Leaving the sequence without power override
    sequence s_seq_exit;
        state_q != ST_IDLE && state_d == ST_IDLE && !f_pmo;
    endsequence

    // Plain acquisition lasts one cycle
    a_acq_plain: assert property (@(posedge CLK) disable iff (RST)
        s_acq_plain |=> state_q == ST_CONV) else $error("acquisition did not end");

    // Stop request ends acquisition at once
    a_acq_stop: assert property (@(posedge CLK) disable iff (RST)
        s_acq_stop |=> state_q == ST_IDLE) else $error("acquisition not stopped");

    // A running conversion is never cut short
    a_conv_finish: assert property (@(posedge CLK) disable iff (RST)
        s_conv_busy |=> state_q == ST_CONV) else $error("conversion cut short");

    // Start still set after a conversion leads to the next acquisition
    a_seq_restart: assert property (@(posedge CLK) disable iff (RST)
        s_restart |=> state_q == ST_ACQ) else $error("sequence not restarted");

    // Power drops when the sequence ends without override
    a_power_down: assert property (@(posedge CLK) disable iff (RST)
        s_seq_exit |=> !pwr_q) else $error("converter left powered");

    // Override keeps a powered converter on
    a_power_hold: assert property (@(posedge CLK) disable iff (RST)
        (pwr_q && f_pmo) |=> pwr_q) else $error("converter powered down under override");

    // Reference choice per setup entry
    a_ref_supply: assert property (@(posedge CLK) disable iff (RST)
        !cur[`ASC_CFG_REF_BIT] |=> CONV_REF == 2'b00) else $error("supply reference not chosen");
    a_ref_external: assert property (@(posedge CLK) disable iff (RST)
        (cur[`ASC_CFG_REF_BIT] && !f_iref) |=> CONV_REF == 2'b01) else $error("external reference not chosen");
    a_ref_internal: assert property (@(posedge CLK) disable iff (RST)
        (cur[`ASC_CFG_REF_BIT] && f_iref) |=> CONV_REF == 2'b10) else $error("internal reference not chosen");

    // Ring index wraps after the last entry
    a_ring_wrap: assert property (@(posedge CLK) disable iff (RST)
        (conv_done && widx_q == 4'hf) |=> widx_q == 4'h0) else $error("ring index did not wrap");

    // Converter sample lands in the current ring entry
    a_sample_store: assert property (@(posedge CLK) disable iff (RST)
        conv_done |=> buf_q[$past(widx_q)] == $past(sample)) else $error("sample not stored");

    // Port read returns the selected entry
    a_port_read: assert property (@(posedge CLK) disable iff (RST)
        (rd && hit_pt) |=> PRDATA[15:0] == $past(port_rd)) else $error("port read wrong");

    // Software write reaches the selected buffer entry
    a_buf_write: assert property (@(posedge CLK) disable iff (RST)
        (wr && hit_pt && !sel_q[4] && !conv_done) |=> buf_q[$past(sel_q[3:0])] == $past(PWDATA[15:0]))
        else $error("buffer write lost");

    // Request drops once flag or enable is low
    a_irq_clear: assert property (@(posedge CLK) disable iff (RST)
        !(flag_q && f_ie) |=> !IRQ) else $error("interrupt not withdrawn");
endmodule

// >>> sim/asc_core_model.sv
// Analog converter core model: reference warm-up and one result per channel
// Assumes the sequencer's converter outputs and the same system clock
`timescale 1ns/1ps
module asc_core_model #(
    parameter int WARM_CLKS = 8
) (
    input  wire logic        clk,
    input  wire logic        conv_power,
    input  wire logic        conv_sample,
    input  wire logic [3:0]  conv_channel,
    output logic             ref_ready,
    output logic [11:0]      conv_result
);
    int          warm_q  = 0;
    logic [11:0] noise_q = 12'h000;
    // Reference warms only while powered; idle result keeps changing
    always_ff @(posedge clk) begin
        warm_q  <= conv_power ? warm_q + 1 : 0;
        noise_q <= ~noise_q ^ 12'h5a3;
    end
    assign ref_ready = conv_power && (warm_q >= WARM_CLKS);
    // Result held for the whole conversion phase, bit 11 follows the channel
    assign conv_result = (conv_power && !conv_sample) ?
                         {conv_channel[0], 3'h5, conv_channel, 4'h9} : noise_q;
endmodule

// >>> sim/asc_seq_bench.sv
// Self-checking bench for the converter sequencer and its core model
// Assumes the sequencer and the core model are compiled before it
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_seq_bench;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic        pready, pslverr, ref_ready, conv_power, clk_en, conv_sample, irq, err;
    logic [11:0] conv_result;
    logic [3:0]  conv_channel, sto;
    logic [1:0]  conv_ref, a;
    logic [31:0] seed = 32'hf343f7f8;
    int          num_errors = 0, checks = 0, cycles = 0, gap = 100, hi = 0, div_exp = 1;
    logic [5:0]  rec_q[$];
    int          len_q[$];
    logic [15:0] cfg[3], ctl;
    logic [11:0] ra[3] = '{`ASC_ADDR_BOUNDS, `ASC_ADDR_CONTROL, `ASC_ADDR_STATUS};

    asc_seq uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REF_READY(ref_ready),
        .CONV_RESULT(conv_result), .CONV_POWER(conv_power), .CONV_CLK_EN(clk_en), .CONV_SAMPLE(conv_sample),
        .CONV_CHANNEL(conv_channel), .CONV_REF(conv_ref), .IRQ(irq));
    asc_core_model core (.clk(clk), .conv_power(conv_power), .conv_sample(conv_sample),
        .conv_channel(conv_channel), .ref_ready(ref_ready), .conv_result(conv_result));

    // Random source and expected stored sample
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] fmt(input logic [15:0] c);
        logic [11:0] v;
        v = {c[0], 3'h5, c[3:0], 4'h9};
        return c[4] ? {v, 4'h0} : (c[3] ? {{4{v[11]}}, v} : {4'h0, v});
    endfunction
    // Comparison, verdict and one APB transfer
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {16'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Monitors: timeout, converter clock spacing, acquisition records
    // ----------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            num_errors++;
            complete_run();
        end
        if (clk_en) begin
            if (gap <= 8) chk(gap, div_exp);
            gap = 1;
        end else gap++;
        if (conv_sample) begin
            if (hi == 0) rec_q.push_back({conv_ref, conv_channel});
            hi++;
        end else if (hi > 0) begin
            len_q.push_back(hi);
            hi = 0;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values, buffer reset, unmapped access, reserved bits
        foreach (ra[i]) begin
            apb(0, ra[i], 16'h0);
            chk(rd, 32'h0);
        end
        apb(0, `ASC_ADDR_PORT, 16'h0);
        chk(rd, 32'h0);
        apb(0, 12'h010, 16'h0);
        chk(err, 1'b1);
        ctl = 16'(rnd());
        apb(1, `ASC_ADDR_CONTROL, ctl | 16'hf000);
        apb(0, `ASC_ADDR_CONTROL, 16'h0);
        chk(rd, {20'h0, ctl[11:0]});
        // Selector wraps in four bits, setup select kept
        apb(1, `ASC_ADDR_STATUS, 16'h001f);
        apb(0, `ASC_ADDR_PORT, 16'h0);
        apb(0, `ASC_ADDR_PORT, 16'h0);
        apb(0, `ASC_ADDR_STATUS, 16'h0);
        chk(rd & 32'h1f, 32'h11);
        // Single sequences: every divider and interval code, random setups
        for (int k = 0; k < 4; k++) begin
            apb(1, `ASC_ADDR_STATUS, 16'h0010);
            foreach (cfg[i]) begin
                cfg[i] = 16'(rnd()) & 16'h005f;
                apb(1, `ASC_ADDR_PORT, cfg[i]);
            end
            sto = 4'(rnd());
            r = rnd();
            apb(1, `ASC_ADDR_BOUNDS, {4'h0, sto, 8'h02});
            ctl = {4'h0, 2'(k), 2'(k), r[0], 1'b0, r[1], 1'(k == 3), 4'h0};
            div_exp = 1 << k;
            apb(1, `ASC_ADDR_CONTROL, ctl);
            repeat (200) @(posedge clk);
            rec_q.delete();
            apb(1, `ASC_ADDR_STATUS, 16'h0040);
            apb(1, `ASC_ADDR_CONTROL, ~ctl);
            do apb(0, `ASC_ADDR_STATUS, 16'h0); while (rd[6] !== 1'b0);
            chk(rd[11:5] & 7'h7b, {sto + 4'd2, 2'b00, 1'(k < 2)});
            chk(irq, ctl[5] && k < 2);
            chk(rec_q.size(), 3);
            apb(1, `ASC_ADDR_STATUS, {12'h0, sto});
            foreach (cfg[i]) begin
                apb(0, `ASC_ADDR_PORT, 16'h0);
                chk(rd, {16'h0, fmt(cfg[i])});
                chk(rec_q[i], {cfg[i][6] ? (ctl[7] ? 2'b10 : 2'b01) : 2'b00, cfg[i][3:0]});
            end
            apb(0, `ASC_ADDR_CONTROL, 16'h0);
            chk(rd, ctl);
            chk(conv_power, k == 3);
            apb(0, `ASC_ADDR_STATUS, 16'h0);
            chk(rd[7], ctl[7] && k == 3);
        end
        // Continuous run with extended acquisition, buffer write, stop mid-acquisition
        a = 2'(rnd());
        div_exp = 1;
        apb(1, `ASC_ADDR_STATUS, 16'h0013);
        apb(1, `ASC_ADDR_PORT, 16'h0020 | 16'(rnd() & 32'h1f));
        apb(1, `ASC_ADDR_BOUNDS, 16'h0833);
        apb(1, `ASC_ADDR_CONTROL, 16'h0040 | a);
        len_q.delete();
        apb(1, `ASC_ADDR_STATUS, 16'h0045);
        apb(1, `ASC_ADDR_PORT, 16'hbeef);
        while (len_q.size() < 2) @(posedge clk);
        while (!conv_sample) @(posedge clk);
        apb(1, `ASC_ADDR_STATUS, 16'h0000);
        repeat (3) @(posedge clk);
        chk(conv_sample, 1'b0);
        chk(conv_power, 1'b0);
        chk(len_q[0], 16 * (a + 1));
        chk(len_q[1], 16 * (a + 1));
        apb(1, `ASC_ADDR_STATUS, 16'h0005);
        apb(0, `ASC_ADDR_PORT, 16'h0);
        chk(rd, 32'hbeef);
        complete_run();
    end
endmodule
